// ===== hw/sdg_pkg.sv
// shared constants for the four channel step and direction generator
package sdg_pkg;
   localparam int SDG_CHANNELS = 4;
   localparam int SDG_NUM_OUT = 14;
   localparam int SDG_NUM_IN = 16;
   localparam int SDG_CLK_HZ = 40000000;
   // timing tick and ceiling, in nanoseconds
   localparam int SDG_TICK_NS = 1600;
   localparam int SDG_TMAX_NS = 49600;
   localparam int SDG_CLK_NS = 25;
   localparam int SDG_TICK_CYC = (SDG_TICK_NS + SDG_CLK_NS - 1) / SDG_CLK_NS;
   localparam int SDG_TMAX_TICKS = SDG_TMAX_NS / SDG_TICK_NS;
   localparam int SDG_TW = 5;
   localparam int SDG_TICKW = 7;
   // highest step rate 312.5 kHz: 128 clock cycles per step
   localparam int SDG_MIN_STEP_CYC = 128;
   localparam int SDG_RATE_W = 32;
   localparam int SDG_POS_W = 32;
   localparam logic [SDG_TW-1:0] SDG_TMAX = 5'h1f;
   localparam logic [SDG_TICKW-1:0] SDG_TICK_LAST = 7'h3f;
   typedef enum logic [3:0] {
      SDG_IDLE = 4'h1,
      SDG_HIGH = 4'h2,
      SDG_SPACE = 4'h4,
      SDG_DIRW = 4'h8
   } sdg_state_t;
endpackage

// ===== hw/sdg_channel.sv
// one step and direction channel with phase accumulator and position count
module sdg_channel
   import sdg_pkg::*;
(
   // clock and control
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic tick,
   // shared timing in ticks
   input wire logic [sdg_pkg::SDG_TW-1:0] len_ticks,
   input wire logic [sdg_pkg::SDG_TW-1:0] space_ticks,
   input wire logic [sdg_pkg::SDG_TW-1:0] dir_ticks,
   // rate command
   input wire logic rate_load,
   input wire logic [sdg_pkg::SDG_RATE_W-1:0] rate_in,
   input wire logic heading_in,
   // outputs
   output logic pulse_out,
   output logic heading_out,
   output logic [sdg_pkg::SDG_POS_W-1:0] position
);
   import sdg_pkg::*;

   typedef struct packed {
      sdg_state_t st;
      logic [SDG_RATE_W-1:0] rate;
      logic want_dir;
      logic [SDG_RATE_W-1:0] acc;
      logic pending;
      logic [SDG_TW:0] cnt;
      logic [SDG_TW:0] hold;
      logic pulse;
      logic dir;
      logic [SDG_POS_W-1:0] pos;
   } sdg_ch_t;

   sdg_ch_t s, next_s;
   logic [SDG_RATE_W:0] sum;

   always_comb begin
      next_s = s;
      sum = {1'b0, s.acc} + {1'b0, s.rate};
      if (rate_load) begin // [RULE6]
         next_s.rate = rate_in;
         next_s.want_dir = heading_in;
      end
      next_s.acc = sum[SDG_RATE_W-1:0];
      // a step request waits here while timing guards run
      if (sum[SDG_RATE_W])
         next_s.pending = 1'b1;
      if (tick && s.cnt != '0)
         next_s.cnt = s.cnt - 1'b1;
      // direction hold runs from the falling step edge, beside the space count
      if (tick && s.hold != '0)
         next_s.hold = s.hold - 1'b1;
      case (s.st)
         SDG_IDLE: begin
            if (s.want_dir != s.dir) begin
               // no step in the old heading while the hold time runs
               if (s.hold == '0) begin
                  next_s.dir = s.want_dir; // [RULE11]
                  next_s.cnt = {1'b0, dir_ticks} + 1'b1; // [RULE4]
                  next_s.st = SDG_DIRW;
               end
            end else if (s.pending) begin
               next_s.pending = sum[SDG_RATE_W];
               next_s.pulse = 1'b1;
               next_s.cnt = {1'b0, len_ticks} + 1'b1; // [RULE2]
               next_s.pos = s.dir ? s.pos + 1'b1 : s.pos - 1'b1; // [RULE10]
               next_s.st = SDG_HIGH;
            end
         end
         SDG_HIGH: begin
            if (s.cnt == '0) begin
               next_s.pulse = 1'b0;
               next_s.cnt = {1'b0, space_ticks} + 1'b1; // [RULE2]
               next_s.hold = {1'b0, dir_ticks} + 1'b1; // [RULE4]
               next_s.st = SDG_SPACE;
            end
         end
         SDG_SPACE: if (s.cnt == '0) next_s.st = SDG_IDLE; // [RULE11]
         SDG_DIRW: if (s.cnt == '0) next_s.st = SDG_IDLE; // [RULE11]
         default: next_s.st = SDG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s <= '0;
         s.st <= SDG_IDLE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign pulse_out = s.pulse;
   assign heading_out = s.dir;
   assign position = s.pos;
endmodule

// ===== hw/sdg_top.sv
// four channel step and direction generator with dedicated inputs and outputs
// Functional notes
// RULE1 - four independent channels each drive a step and a direction output, up to 312.5 kHz.
// RULE2 - minimum step length, step space and direction time are enforced on every channel.
// RULE3 - each timing setting rounds up to a whole 1.6 us tick and is capped at 49.6 us.
// RULE4 - one direction time covers both setup and hold; the host gives the larger of the two.
// RULE5 - one shared set of timings applies to all four channels.
// RULE6 - each channel takes its new step rate at its own moment.
// RULE7 - the 14 dedicated outputs change together in one update.
// RULE8 - the 16 dedicated inputs are captured together in one latch event.
// RULE9 - each channel's feedback position is captured at its own moment.
// RULE10 - position counts up for forward steps and down for reverse steps.
// RULE11 - direction changes only after step space, and the next step waits the direction time.
module sdg_top
   import sdg_pkg::*;
#(
   parameter int CHANNELS = sdg_pkg::SDG_CHANNELS
)(
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // shared timing, in ticks of 1.6 us, host side already rounded up
   input wire logic [sdg_pkg::SDG_TW-1:0] len_set,
   input wire logic [sdg_pkg::SDG_TW-1:0] space_set,
   input wire logic [sdg_pkg::SDG_TW-1:0] dir_set,
   // per channel rate command
   input wire logic [CHANNELS-1:0] rate_load,
   input wire logic [CHANNELS*sdg_pkg::SDG_RATE_W-1:0] rate_in,
   input wire logic [CHANNELS-1:0] heading_in,
   // per channel position capture
   input wire logic [CHANNELS-1:0] pos_capture,
   output logic [CHANNELS*sdg_pkg::SDG_POS_W-1:0] pos_latched,
   // dedicated io
   input wire logic out_load,
   input wire logic [sdg_pkg::SDG_NUM_OUT-1:0] out_value,
   input wire logic in_capture,
   input wire logic [sdg_pkg::SDG_NUM_IN-1:0] dedicated_input_n,
   output logic [sdg_pkg::SDG_NUM_IN-1:0] in_latched,
   output logic [sdg_pkg::SDG_NUM_OUT-1:0] dedicated_output_n,
   // motor pins
   output logic [CHANNELS-1:0] pulse_out_n,
   output logic [CHANNELS-1:0] heading_out_n
);
   import sdg_pkg::*;

   // pin map and position bus serve one to four channels only
   if (CHANNELS < 1 || CHANNELS > SDG_CHANNELS) begin : gen_bad_channels
      $error("sdg_top: CHANNELS out of range");
   end

   typedef struct packed {
      logic [SDG_TICKW-1:0] pre;
      logic tick;
      logic [SDG_TW-1:0] len;
      logic [SDG_TW-1:0] space;
      logic [SDG_TW-1:0] dirt;
      logic [SDG_NUM_IN-1:0] sync1;
      logic [SDG_NUM_IN-1:0] sync2;
      logic [SDG_NUM_IN-1:0] sync3;
      logic [SDG_NUM_IN-1:0] inl;
      logic [SDG_NUM_OUT-1:0] outs;
      logic [CHANNELS*SDG_POS_W-1:0] posl;
   } sdg_top_t;

   sdg_top_t r, next_r;
   logic [CHANNELS-1:0] ch_pulse;
   logic [CHANNELS-1:0] ch_dir;
   logic [CHANNELS*SDG_POS_W-1:0] ch_pos;

   // clamp a setting to the ceiling
   function automatic logic [SDG_TW-1:0] cap(input logic [SDG_TW-1:0] v);
      cap = (v > SDG_TMAX) ? SDG_TMAX : v; // [RULE3]
   endfunction

   always_comb begin
      next_r = r;
      // 1.6 us tick from the 40 MHz clock
      next_r.tick = (r.pre == SDG_TICK_LAST); // [RULE3]
      next_r.pre = next_r.tick ? '0 : r.pre + 1'b1;
      // settings shared by all channels, a single register set
      next_r.len = cap(len_set); // [RULE5]
      next_r.space = cap(space_set);
      next_r.dirt = cap(dir_set);
      next_r.sync1 = dedicated_input_n;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      // only bits on which stages two and three agree move into the latch
      if (in_capture)
         next_r.inl = (r.sync2 & r.sync3) | (r.inl & (r.sync2 | r.sync3)); // [RULE8]
      if (out_load)
         next_r.outs = out_value; // [RULE7]
      for (int i = 0; i < CHANNELS; i++) begin
         if (pos_capture[i])
            next_r.posl[i*SDG_POS_W +: SDG_POS_W] = ch_pos[i*SDG_POS_W +: SDG_POS_W]; // [RULE9]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst)
         r <= '0;
      else if (ce)
         r <= next_r;
   end

   // channels count ticks against the same shared settings
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : gen_ch
         sdg_channel u_ch (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .ce(ce),
            .tick(r.tick),
            .len_ticks(r.len),
            .space_ticks(r.space),
            .dir_ticks(r.dirt),
            .rate_load(rate_load[g]),
            .rate_in(rate_in[g*SDG_RATE_W +: SDG_RATE_W]),
            .heading_in(heading_in[g]),
            .pulse_out(ch_pulse[g]), // [RULE1]
            .heading_out(ch_dir[g]),
            .position(ch_pos[g*SDG_POS_W +: SDG_POS_W])
         );
      end
   endgenerate

   assign pulse_out_n = ch_pulse;
   assign heading_out_n = ch_dir;
   assign pos_latched = r.posl;
   assign in_latched = r.inl;
   assign dedicated_output_n = r.outs;
endmodule

// ===== bench/sdg_motor.sv
// far side model: a driver stage that counts steps by the heading line
module sdg_motor(
   input wire logic sys_clk,
   input wire logic [3:0] pulse_out_n,
   input wire logic [3:0] heading_out_n,
   output int net [4]
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] last = 4'h0;
   initial for (int i = 0; i < 4; i++) net[i] = 0;
   // counts on the rising step edge, one cycle late, heading is still held then
   always @(posedge sys_clk) begin
      last <= pulse_out_n;
      for (int i = 0; i < 4; i++)
         if (pulse_out_n[i] && !last[i]) net[i] <= net[i] + (heading_out_n[i] ? 1 : -1);
   end
endmodule

// ===== bench/sdg_top_properties.sv
// concurrent checks on the generator's ports
module sdg_properties #(
   parameter int CHANNELS = 4
)(
   // clock and control
   input wire logic sys_clk, nrst, ce, out_load, in_capture,
   input wire logic [CHANNELS-1:0] pos_capture,
   input wire logic [13:0] out_value,
   input wire logic [4:0] len_set, dir_set,
   // outputs
   input wire logic [CHANNELS*32-1:0] pos_latched,
   input wire logic [15:0] in_latched,
   input wire logic [13:0] dedicated_output_n,
   input wire logic [CHANNELS-1:0] pulse_out_n, heading_out_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   int high_cnt, since_fall, since_dir;
   // channel zero cycle counters; since_fall and since_dir saturate so long idle spells never wrap
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         high_cnt <= 0;
         since_fall <= 4095;
         since_dir <= 4095;
      end else begin
         high_cnt <= pulse_out_n[0] ? high_cnt + 1 : 0;
         if ($fell(pulse_out_n[0])) since_fall <= 0;
         else if (since_fall < 4095) since_fall <= since_fall + 1;
         if ($changed(heading_out_n[0])) since_dir <= 0;
         else if (since_dir < 4095) since_dir <= since_dir + 1;
      end
   end
   pulse_min_a: assert property ($fell(pulse_out_n[0]) |-> high_cnt >= 64 * len_set) else $error("step short");
   dir_setup_a: assert property ($rose(pulse_out_n[0]) |-> since_dir >= 64 * dir_set) else $error("setup short");
   dir_hold_a: assert property ($changed(heading_out_n[0]) |-> since_fall >= 64 * dir_set) else $error("hold short");
   out_upd_a: assert property (ce && out_load |=> dedicated_output_n == $past(out_value)) else $error("load");
   out_hold_a: assert property (!out_load |=> $stable(dedicated_output_n)) else $error("out moved");
   in_hold_a: assert property (!in_capture |=> $stable(in_latched)) else $error("in moved");
   pos_hold_a: assert property (!pos_capture[0] |=> $stable(pos_latched[31:0])) else $error("pos moved");
   pulse_len_a: assert property ($rose(pulse_out_n[0]) |=> pulse_out_n[0] [*8]) else $error("short");
   pulse_space_a: assert property ($fell(pulse_out_n[1]) |=> !pulse_out_n[1] [*8]) else $error("space");
   dir_quiet_a: assert property ($changed(heading_out_n[0]) |-> !pulse_out_n[0] && !$past(pulse_out_n[0]))
      else $error("dir in pulse");
   freeze_a: assert property (!ce |=> $stable(pulse_out_n) && $stable(heading_out_n)) else $error("not frozen");
endmodule
bind sdg_top sdg_properties #(.CHANNELS(CHANNELS)) prop_u(
   .sys_clk(sys_clk),
   .nrst(nrst),
   .ce(ce),
   .out_load(out_load),
   .in_capture(in_capture),
   .pos_capture(pos_capture),
   .out_value(out_value),
   .len_set(len_set),
   .dir_set(dir_set),
   .pos_latched(pos_latched),
   .in_latched(in_latched),
   .dedicated_output_n(dedicated_output_n),
   .pulse_out_n(pulse_out_n),
   .heading_out_n(heading_out_n)
);

// ===== bench/tb_top.sv
// self-checking bench for the step and direction generator
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("wrong value %0t %0h %0h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sdg_pkg::*;
   logic sys_clk = 0, nrst = 0, ce = 1, out_load = 0, in_capture = 0;
   // one time for setup and hold, the larger of the two
   logic [4:0] len_set = 5'h01, space_set = 5'h01, dir_set = 5'h02;
   logic [3:0] rate_load = 0, heading_in = 0, pos_capture = 0, pulse_out_n, heading_out_n;
   logic [127:0] rate_in = 0, pos_latched;
   logic [13:0] out_value = 0, dedicated_output_n;
   logic [15:0] dedicated_input_n = 0, in_latched;
   int n_errors = 0, check_count = 0, cyc = 0;
   int net [4];
   sdg_top dut_u(
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .len_set(len_set),
      .space_set(space_set),
      .dir_set(dir_set),
      .rate_load(rate_load),
      .rate_in(rate_in),
      .heading_in(heading_in),
      .pos_capture(pos_capture),
      .pos_latched(pos_latched),
      .out_load(out_load),
      .out_value(out_value),
      .in_capture(in_capture),
      .dedicated_input_n(dedicated_input_n),
      .in_latched(in_latched),
      .dedicated_output_n(dedicated_output_n),
      .pulse_out_n(pulse_out_n),
      .heading_out_n(heading_out_n)
   );
   sdg_motor mot_u(.sys_clk(sys_clk), .pulse_out_n(pulse_out_n), .heading_out_n(heading_out_n), .net(net));
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test;
      end
   end
   task go(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task t_io;
      @(posedge sys_clk) out_value <= 14'h2a5a; out_load <= 1'b1; dedicated_input_n <= 16'hc3a5;
      @(posedge sys_clk) out_load <= 1'b0; out_value <= 14'h15a5;
      #1 `CHK(dedicated_output_n, 14'h2a5a)
      go(4);
      @(posedge sys_clk) in_capture <= 1'b1;
      @(posedge sys_clk) in_capture <= 1'b0; dedicated_input_n <= 16'h3c5a;
      #1 `CHK(in_latched, 16'hc3a5)
      go(5);
      `CHK({dedicated_output_n, in_latched}, {14'h2a5a, 16'hc3a5})
      $display("test io done");
   endtask
   task t_step;
      logic [31:0] p0;
      @(posedge sys_clk) rate_in <= {64'h0, 32'h00800000, 32'h00800000}; heading_in <= 4'h1; rate_load <= 4'h3;
      @(posedge sys_clk) rate_load <= 4'h0;
      go(4000);
      @(posedge sys_clk) pos_capture <= 4'h1;
      @(posedge sys_clk) pos_capture <= 4'h0;
      #1 p0 = pos_latched[31:0];
      `CHK(p0, net[0])
      `CHK(net[0] > 4, 1'b1)
      `CHK(pos_latched[63:32], 32'h0)
      `CHK({net[2], net[3]}, 64'h0)
      go(300);
      @(posedge sys_clk) pos_capture <= 4'h2;
      @(posedge sys_clk) pos_capture <= 4'h0;
      #1 `CHK(pos_latched[63:32], net[1])
      `CHK({net[1] < 0, pos_latched[31:0]}, {1'b1, p0})
      `CHK(heading_out_n, 4'h1)
      $display("test step done");
   endtask
   task t_rev;
      int n0;
      n0 = net[0];
      @(posedge sys_clk) heading_in <= 4'h0; rate_load <= 4'h1;
      @(posedge sys_clk) rate_load <= 4'h0;
      go(4000);
      @(posedge sys_clk) pos_capture <= 4'h1;
      @(posedge sys_clk) pos_capture <= 4'h0;
      #1 `CHK(pos_latched[31:0], net[0])
      `CHK({net[0] < n0, heading_out_n[0]}, 2'h2)
      @(posedge sys_clk) ce <= 1'b0;
      go(20);
      ce <= 1'b1;
      $display("test reverse done");
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      go(10);
      nrst <= 1'b1;
      t_io;
      t_step;
      t_rev;
      end_of_test;
   end
endmodule
